// *** rtl/tlf_pkg.sv ***
// Package for the torque limit and forced stop block: map, fields, resets, states
package tlf_pkg;
    // Register byte offsets on the APB slave
    localparam logic [7:0] ADDR_FWD_INT = 8'h00;
    localparam logic [7:0] ADDR_REV_INT = 8'h04;
    localparam logic [7:0] ADDR_FWD_EXT = 8'h08;
    localparam logic [7:0] ADDR_REV_EXT = 8'h0C;
    localparam logic [7:0] ADDR_ASSIGN  = 8'h10;
    localparam logic [7:0] ADDR_STATUS  = 8'h14;
    localparam logic [7:0] ADDR_MASK    = 8'h18;
    localparam logic [7:0] ADDR_LIMITS  = 8'h1C;
    localparam logic [7:0] ADDR_FLAGS   = 8'h20;

    // Cap settings in 1 % of rated torque
    localparam logic [9:0] CAP_MAX     = 10'h320;
    localparam logic [9:0] INT_CAP_RST = 10'h320;
    localparam logic [9:0] EXT_CAP_RST = 10'h064;

    // Assignment register fields
    localparam int         ASG_FWD_REQ  = 0;
    localparam int         ASG_REV_REQ  = 1;
    localparam int         ASG_FLAG_OUT = 2;
    localparam int         ASG_STOP_IN  = 3;
    localparam int         ASG_METH_LO  = 4;
    localparam logic [5:0] ASSIGN_RST   = 6'h00;

    // Stop methods
    localparam logic [1:0] METH_DYN_BRAKE = 2'h0;
    localparam logic [1:0] METH_FREE_RUN  = 2'h1;
    localparam logic [1:0] METH_DECEL     = 2'h2;

    // Status / mask, limits and flags register bit positions
    localparam int         EV_LIMIT_ON = 0;
    localparam int         EV_STOP_ON  = 1;
    localparam int         EV_STOP_OFF = 2;
    localparam int         EV_W        = 3;
    localparam int         LIM_REV_LO  = 16;
    localparam int         FLG_STATE_LO = 4;

    // Forced stop sequence states
    typedef enum logic [4:0] {
        FS_RUN   = 5'h01,
        FS_STOP  = 5'h02,
        FS_HOLD  = 5'h04,
        FS_OFFED = 5'h08,
        FS_BBED  = 5'h10
    } tlf_fs_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } tlf_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } tlf_apb_rsp_t;
endpackage

// *** rtl/tlf_torque_limit.sv ***
// Torque limit selection and forced stop sequencing with APB registers
//
// Behaviour
// - Output torque never exceeds forward cap forward, reverse cap in reverse.
// - Internal caps take 0 to 800 percent, reset 800, act at once.
// - External caps take 0 to 800 percent, reset 100, act at once.
// - Forward request closed: forward limit is min of forward internal and external.
// - Forward request open: forward limit is the forward internal cap.
// - Reverse request closed: reverse limit is min of reverse internal and external.
// - Reverse request open: reverse limit is the reverse internal cap.
// - Limit requests do nothing until their input assignment bit is set.
// - Torque-limited flag is high exactly while output torque is being clipped.
// - Torque-limited flag drives its pin only when its output is assigned.
// - Forced stop needs its input assigned; stops by brake, free run or decel.
// - Stop input closed allows running; open stops the motor.
// - Forced stop shows on both the panel and the digital operator.
// - Forced stop is independent of the hardware base block path.
// - Servo-on during open stop latches it until off, base block, servo-on.
// - Output torque never exceeds the connected motor's maximum torque.
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module tlf_torque_limit
    import tlf_pkg::*;
#(
    parameter int CAP_W = 10,
    parameter int TQ_W  = 12
) (
    input  wire logic                   core_clk_i,
    input  wire logic                   nrst_i,
    input  wire tlf_apb_req_t           apb_req_i,
    output tlf_apb_rsp_t                apb_rsp_o,
    input  wire logic                   fwd_limit_request_i,
    input  wire logic                   rev_limit_request_i,
    input  wire logic                   forced_stop_input_i,
    input  wire logic                   servo_on_cmd_i,
    input  wire logic                   servo_off_cmd_i,
    input  wire logic                   base_block_state_i,
    input  wire logic [CAP_W-1:0]       motor_max_torque_i,
    input  wire logic signed [TQ_W-1:0] torque_cmd_i,
    output logic signed [TQ_W-1:0]      torque_out_o,
    output logic                        torque_limited_flag_o,
    output logic                        torque_limited_flag_oe_o,
    output logic                        forced_stop_o,
    output logic [1:0]                  stop_method_o,
    output logic                        panel_stop_disp_o,
    output logic                        operator_stop_disp_o,
    output logic                        irq_o
);
    // Caps need ten bits for 800; torque must hold a cap with a sign bit
    if (CAP_W != 10 || TQ_W < CAP_W + 2) begin : g_bad_width
        $error("tlf_torque_limit: CAP_W must be 10 and TQ_W at least CAP_W+2");
    end

    typedef struct packed {
        logic [CAP_W-1:0]       fwd_int;
        logic [CAP_W-1:0]       rev_int;
        logic [CAP_W-1:0]       fwd_ext;
        logic [CAP_W-1:0]       rev_ext;
        logic [5:0]             asg;
        logic [EV_W-1:0]        status;
        logic [EV_W-1:0]        mask;
        logic [2:0]             sync_m;
        logic [2:0]             sync_s;
        tlf_fs_state_t          fs;
        logic signed [TQ_W-1:0] tq;
        logic                   limited;
        logic [31:0]            prdata;
        logic                   pslverr;
    } tlf_state_t;

    tlf_state_t s_q;
    tlf_state_t s_d;

    function automatic logic [CAP_W-1:0] cap_min(input logic [CAP_W-1:0] a,
                                                 input logic [CAP_W-1:0] b);
        return (a < b) ? a : b;
    endfunction

    // A written cap above 800 % is held at 800 % rather than wrapped
    function automatic logic [CAP_W-1:0] cap_wr(input logic [31:0] w);
        return (w > 32'(CAP_MAX)) ? CAP_MAX : w[CAP_W-1:0];
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= ADDR_FLAGS);
    endfunction

    function automatic logic signed [TQ_W-1:0] widen(input logic [CAP_W-1:0] v);
        return $signed({{(TQ_W-CAP_W){1'b0}}, v});
    endfunction

    logic                   wr_acc;
    logic [CAP_W-1:0]       fwd_lim;
    logic [CAP_W-1:0]       rev_lim;
    logic [CAP_W-1:0]       fwd_eff;
    logic [CAP_W-1:0]       rev_eff;
    logic                   forced_stop_input_open;
    logic                   stopped;
    logic [EV_W-1:0]        ev;
    logic [EV_W-1:0]        w1c;
    logic                   clip;
    logic signed [TQ_W-1:0] tq_next;

    // Limit selection from synchronised requests, re-evaluated every cycle
    always_comb begin
        fwd_lim = s_q.fwd_int;
        if (s_q.asg[ASG_FWD_REQ] && s_q.sync_s[0]) begin
            fwd_lim = cap_min(s_q.fwd_int, s_q.fwd_ext);
        end
        rev_lim = s_q.rev_int;
        if (s_q.asg[ASG_REV_REQ] && s_q.sync_s[1]) begin
            rev_lim = cap_min(s_q.rev_int, s_q.rev_ext);
        end
        fwd_eff = cap_min(fwd_lim, motor_max_torque_i);
        rev_eff = cap_min(rev_lim, motor_max_torque_i);
    end

    // Forced stop only watches its input once assigned; base block is not an input here
    assign forced_stop_input_open = s_q.asg[ASG_STOP_IN] && !s_q.sync_s[2];
    assign stopped   = (s_q.fs != FS_RUN);

    always_comb begin
        s_d     = s_q;
        wr_acc  = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite
                  && mapped(apb_req_i.paddr);
        w1c     = '0;
        clip    = 1'b0;
        tq_next = torque_cmd_i;

        // Input synchronisers: first stage feeds only the second
        s_d.sync_m = {forced_stop_input_i, rev_limit_request_i, fwd_limit_request_i};
        s_d.sync_s = s_q.sync_m;

        // Clamp the command to the direction's cap
        if (torque_cmd_i > widen(fwd_eff)) begin
            tq_next = widen(fwd_eff);
            clip    = 1'b1;
        end else if (torque_cmd_i < -widen(rev_eff)) begin
            tq_next = -widen(rev_eff);
            clip    = 1'b1;
        end
        // Brake and free-run stops cut torque; decel is left to the speed loop
        if (stopped && (s_q.asg[ASG_METH_LO +: 2] != METH_DECEL)) begin
            tq_next = '0;
            clip    = 1'b0;
        end
        s_d.tq      = tq_next;
        s_d.limited = clip;

        // Forced stop sequence
        case (s_q.fs)
            FS_RUN: begin
                if (forced_stop_input_open) begin
                    s_d.fs = FS_STOP;
                end
            end
            FS_STOP: begin
                if (servo_on_cmd_i) begin
                    s_d.fs = FS_HOLD;
                end else if (!forced_stop_input_open) begin
                    s_d.fs = FS_RUN;
                end
            end
            FS_HOLD: begin
                if (servo_off_cmd_i) begin
                    s_d.fs = FS_OFFED;
                end
            end
            FS_OFFED: begin
                if (base_block_state_i) begin
                    s_d.fs = FS_BBED;
                end
            end
            FS_BBED: begin
                if (servo_on_cmd_i) begin
                    s_d.fs = forced_stop_input_open ? FS_HOLD : FS_RUN;
                end
            end
            default: begin
                s_d.fs = FS_STOP;
            end
        endcase

        // Events: limiting began, stop entered, stop released
        ev              = '0;
        ev[EV_LIMIT_ON] = clip && !s_q.limited;
        ev[EV_STOP_ON]  = !stopped && (s_d.fs != FS_RUN);
        ev[EV_STOP_OFF] = stopped && (s_d.fs == FS_RUN);

        // Register writes take effect at the access edge
        if (wr_acc) begin
            case (apb_req_i.paddr)
                ADDR_FWD_INT: s_d.fwd_int = cap_wr(apb_req_i.pwdata);
                ADDR_REV_INT: s_d.rev_int = cap_wr(apb_req_i.pwdata);
                ADDR_FWD_EXT: s_d.fwd_ext = cap_wr(apb_req_i.pwdata);
                ADDR_REV_EXT: s_d.rev_ext = cap_wr(apb_req_i.pwdata);
                ADDR_ASSIGN:  s_d.asg     = apb_req_i.pwdata[5:0];
                ADDR_STATUS:  w1c         = apb_req_i.pwdata[EV_W-1:0];
                ADDR_MASK:    s_d.mask    = apb_req_i.pwdata[EV_W-1:0];
                default:      s_d.mask    = s_q.mask;
            endcase
        end
        // A new event beats a write-one-to-clear in the same cycle
        s_d.status = (s_q.status & ~w1c) | ev;

        // Read data is captured in the setup cycle and held through access
        if (apb_req_i.psel && !apb_req_i.penable) begin
            s_d.pslverr = !mapped(apb_req_i.paddr);
            s_d.prdata  = '0;
            case (apb_req_i.paddr)
                ADDR_FWD_INT: s_d.prdata[CAP_W-1:0] = s_q.fwd_int;
                ADDR_REV_INT: s_d.prdata[CAP_W-1:0] = s_q.rev_int;
                ADDR_FWD_EXT: s_d.prdata[CAP_W-1:0] = s_q.fwd_ext;
                ADDR_REV_EXT: s_d.prdata[CAP_W-1:0] = s_q.rev_ext;
                ADDR_ASSIGN:  s_d.prdata[5:0]       = s_q.asg;
                ADDR_STATUS:  s_d.prdata[EV_W-1:0]  = s_q.status;
                ADDR_MASK:    s_d.prdata[EV_W-1:0]  = s_q.mask;
                ADDR_LIMITS: begin
                    s_d.prdata[CAP_W-1:0]                = fwd_eff;
                    s_d.prdata[LIM_REV_LO +: CAP_W]      = rev_eff;
                end
                ADDR_FLAGS: begin
                    s_d.prdata[0]                 = s_q.limited;
                    s_d.prdata[1]                 = stopped;
                    s_d.prdata[FLG_STATE_LO +: 5] = s_q.fs;
                end
                default:      s_d.prdata = '0;
            endcase
        end
    end

    // Single state register; synchronous reset
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            s_q         <= '0;
            s_q.fwd_int <= INT_CAP_RST;
            s_q.rev_int <= INT_CAP_RST;
            s_q.fwd_ext <= EXT_CAP_RST;
            s_q.rev_ext <= EXT_CAP_RST;
            s_q.asg     <= ASSIGN_RST;
            s_q.fs      <= FS_RUN;
        end else begin
            s_q <= s_d;
        end
    end

    // Zero-wait slave: answer in the first access cycle
    assign apb_rsp_o.pready  = apb_req_i.psel && apb_req_i.penable;
    assign apb_rsp_o.prdata  = s_q.prdata;
    assign apb_rsp_o.pslverr = s_q.pslverr;

    assign torque_out_o             = s_q.tq;
    assign torque_limited_flag_o    = s_q.limited && s_q.asg[ASG_FLAG_OUT];
    assign torque_limited_flag_oe_o = s_q.asg[ASG_FLAG_OUT];
    assign forced_stop_o            = stopped;
    assign stop_method_o            = s_q.asg[ASG_METH_LO +: 2];
    assign panel_stop_disp_o        = stopped;
    assign operator_stop_disp_o     = stopped;
    assign irq_o                    = |(s_q.status & s_q.mask);

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    a_fwd_torque_cap: assert property (
        $signed(torque_out_o) <= widen($past(fwd_eff)))
        else $error("forward torque above forward cap");
    a_rev_torque_cap: assert property (
        $signed(torque_out_o) >= -widen($past(rev_eff)))
        else $error("reverse torque above reverse cap");
    a_cap_range: assert property (
        s_q.fwd_int <= CAP_MAX && s_q.rev_int <= CAP_MAX)
        else $error("internal cap above 800");
    a_ext_cap_range: assert property (
        s_q.fwd_ext <= CAP_MAX && s_q.rev_ext <= CAP_MAX)
        else $error("external cap above 800");
    a_fwd_req_min: assert property (
        s_q.asg[ASG_FWD_REQ] && s_q.sync_s[0] |-> fwd_lim <= s_q.fwd_ext)
        else $error("forward request ignores external cap");
    a_fwd_int_only: assert property (
        !(s_q.asg[ASG_FWD_REQ] && s_q.sync_s[0]) |-> fwd_lim == s_q.fwd_int)
        else $error("forward limit not internal cap");
    a_rev_req_min: assert property (
        s_q.asg[ASG_REV_REQ] && s_q.sync_s[1] |-> rev_lim <= s_q.rev_ext)
        else $error("reverse request ignores external cap");
    a_rev_int_only: assert property (
        !(s_q.asg[ASG_REV_REQ] && s_q.sync_s[1]) |-> rev_lim == s_q.rev_int)
        else $error("reverse limit not internal cap");
    // Same-cycle check: an assignment written at this edge may legally change the limit next
    a_req_unassigned: assert property (
        !s_q.asg[ASG_FWD_REQ] && !s_q.asg[ASG_REV_REQ]
        |-> fwd_lim == s_q.fwd_int && rev_lim == s_q.rev_int)
        else $error("unassigned request changed the limit");
    a_flag_gate: assert property (
        !torque_limited_flag_oe_o |-> !torque_limited_flag_o)
        else $error("flag driven while unassigned");
    a_stop_entry: assert property (
        s_q.fs == FS_RUN && forced_stop_input_open |=> forced_stop_o ##1 panel_stop_disp_o)
        else $error("open stop input did not stop the motor");
    a_stop_hold: assert property (
        s_q.fs == FS_HOLD && !servo_off_cmd_i |=> s_q.fs == FS_HOLD)
        else $error("latched stop left without servo off");
    a_motor_max: assert property (
        $signed(torque_out_o) <= widen($past(motor_max_torque_i)))
        else $error("torque above motor maximum");
    a_sync_delay: assert property (
        s_q.sync_s[0] == $past(fwd_limit_request_i, 2))
        else $error("request synchroniser depth wrong");
endmodule

// *** tb/tlf_host_model.sv ***
// Host controller model: drives the limit requests, stop input and servo commands
`timescale 1ns/10ps
module tlf_host_model (
    input  wire logic       core_clk_i,
    input  wire logic [5:0] want_i,
    output logic            fwd_limit_request_o,
    output logic            rev_limit_request_o,
    output logic            forced_stop_input_o,
    output logic            servo_on_cmd_o,
    output logic            servo_off_cmd_o,
    output logic            base_block_state_o
);
    // Stop input starts closed so the drive may run out of reset
    initial begin
        {base_block_state_o, servo_off_cmd_o, servo_on_cmd_o} = 3'h0;
        {forced_stop_input_o, rev_limit_request_o, fwd_limit_request_o} = 3'h4;
    end

    // Lines move once per control cycle, right after the edge, like a real host
    always @(posedge core_clk_i) begin
        {fwd_limit_request_o, rev_limit_request_o} <= {want_i[0], want_i[1]};
        forced_stop_input_o <= want_i[2];
        servo_on_cmd_o      <= want_i[3];
        servo_off_cmd_o     <= want_i[4];
        base_block_state_o  <= want_i[5];
    end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the torque limit and forced stop block
`timescale 1ns/10ps
module testbench import tlf_pkg::*; ;
    logic               core_clk_i = 1'b0;
    logic               nrst_i     = 1'b0;
    tlf_apb_req_t       req        = '0;
    tlf_apb_rsp_t       rsp;
    logic [5:0]         want       = 6'h04;
    logic               fwd_rq, rev_rq, stop_in, son, soff, bb;
    logic [9:0]         mmax       = 10'h3FF;
    logic signed [11:0] cmd        = '0;
    logic signed [11:0] tq;
    logic               flag, oe, fs, pdisp, odisp, irq;
    logic [1:0]         meth;
    logic               chk        = 1'b0;
    logic [32:0]        q[$];
    logic [32:0]        got, ev;
    logic [31:0]        rs         = 32'h53;
    logic [5:0]         asg        = 6'h00;
    logic               stopd      = 1'b0;
    logic               irq_e      = 1'b0;
    int                 cp[4]      = '{800, 800, 100, 100};
    int                 fails      = 0;
    int                 tests_run  = 0;

    initial forever #5 core_clk_i = ~core_clk_i;

    tlf_host_model host (.core_clk_i(core_clk_i), .want_i(want),
        .fwd_limit_request_o(fwd_rq), .rev_limit_request_o(rev_rq),
        .forced_stop_input_o(stop_in), .servo_on_cmd_o(son),
        .servo_off_cmd_o(soff), .base_block_state_o(bb));

    tlf_torque_limit dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .apb_req_i(req),
        .apb_rsp_o(rsp), .fwd_limit_request_i(fwd_rq), .rev_limit_request_i(rev_rq),
        .forced_stop_input_i(stop_in), .servo_on_cmd_i(son), .servo_off_cmd_i(soff),
        .base_block_state_i(bb), .motor_max_torque_i(mmax), .torque_cmd_i(cmd),
        .torque_out_o(tq), .torque_limited_flag_o(flag), .torque_limited_flag_oe_o(oe),
        .forced_stop_o(fs), .stop_method_o(meth), .panel_stop_disp_o(pdisp),
        .operator_stop_disp_o(odisp), .irq_o(irq));

    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction

    // Expected port picture from the cap settings and the host's lines
    function automatic logic [32:0] exp_out();
        int   fl, rl, o;
        logic lim;
        fl = (want[0] && asg[0] && cp[2] < cp[0]) ? cp[2] : cp[0];
        rl = (want[1] && asg[1] && cp[3] < cp[1]) ? cp[3] : cp[1];
        fl = (int'(mmax) < fl) ? int'(mmax) : fl;
        rl = (int'(mmax) < rl) ? int'(mmax) : rl;
        o = (cmd > fl) ? fl : ((cmd < -rl) ? -rl : int'(cmd));
        lim = (o != cmd);
        if (stopd && asg[5:4] != 2'h2) begin
            o = 0;
            lim = 1'b0;
        end
        return {13'h0, asg[5:4], irq_e, {3{stopd}}, asg[2], lim & asg[2], o[11:0]};
    endfunction

    // One APB transfer; a read leaves its expected {pslverr, prdata} in the queue
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        req <= '{1'b1, 1'b0, wr, a, d};
        if (!wr) q.push_back(e);
        @(posedge core_clk_i);
        req.penable <= 1'b1;
        // Wait as long as the slave asks; only the watchdog ends a hang
        do begin
            @(posedge core_clk_i);
        end while (rsp.pready !== 1'b1);
        req <= '0;
        @(posedge core_clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, '0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        apb(1'b0, a, '0, e);
    endtask

    task automatic cap(input int k, input int v);
        cp[k] = v;
        wr(8'(k * 4), 32'(v));
    endtask

    task automatic set_asg(input logic [5:0] v);
        asg = v;
        wr(ADDR_ASSIGN, {26'h0, v});
    endtask

    // Outputs settle within the synchroniser latency; then ask the monitor to look
    task automatic settle();
        repeat (6) @(posedge core_clk_i);
        q.push_back(exp_out());
        chk <= 1'b1;
        @(posedge core_clk_i);
        chk <= 1'b0;
    endtask

    task automatic pulse(input int b);
        want[b] <= 1'b1;
        @(posedge core_clk_i);
        want[b] <= 1'b0;
        @(posedge core_clk_i);
    endtask

    // Monitor: every read answer or output check takes the oldest note
    always @(posedge core_clk_i) begin
        if (chk || (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1)) begin
            got = chk ? {13'h0, meth, irq, fs, pdisp, odisp, oe, flag, tq}
                      : {rsp.pslverr, rsp.prdata};
            ev = q.pop_front();
            tests_run++;
            if (got !== ev) begin
                fails++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, ev);
            end
        end
    end

    task automatic stop_test();
        if (q.size() != 0) fails++;
        if (fails == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Watchdog sized well above the whole sequence
    initial begin
        repeat (20000) @(posedge core_clk_i);
        fails++;
        stop_test();
    end

    initial begin
        repeat (2) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        @(posedge core_clk_i);
        rd(ADDR_FWD_INT, {23'h0, INT_CAP_RST});
        rd(ADDR_REV_INT, {23'h0, INT_CAP_RST});
        rd(ADDR_FWD_EXT, {23'h0, EXT_CAP_RST});
        rd(ADDR_REV_EXT, {23'h0, EXT_CAP_RST});
        rd(8'h24, 33'h100000000);
        wr(ADDR_FWD_INT, 32'h3FF);
        rd(ADDR_FWD_INT, {23'h0, CAP_MAX});
        // Requests and stop input ignored while unassigned
        want <= 6'h03;
        cmd  <= 12'h1F4;
        settle();
        set_asg(6'h07);
        settle();
        rd(ADDR_LIMITS, 33'h000640064);
        cmd <= 12'hE0C;
        settle();
        for (int i = 0; i < 24; i++) begin
            for (int k = 0; k < 4; k++) cap(k, int'(rnd() % 801));
            set_asg(6'(rnd() % 8));
            mmax <= 10'(rnd());
            cmd  <= 12'(int'(rnd() % 2001) - 1000);
            want <= {4'h1, 2'(rnd())};
            settle();
        end
        // Interrupt: raise on a new clip, mask, clear by writing one
        cap(0, 800);
        mmax <= 10'h3FF;
        cmd  <= '0;
        want <= 6'h04;
        set_asg(6'h07);
        wr(ADDR_STATUS, 32'h7);
        wr(ADDR_MASK, 32'h1);
        settle();
        cmd <= 12'h384;
        irq_e = 1'b1;
        settle();
        rd(ADDR_STATUS, 33'h1);
        wr(ADDR_STATUS, 32'h1);
        irq_e = 1'b0;
        settle();
        wr(ADDR_MASK, 32'h0);
        // Every stop method: open stops, close resumes
        cmd <= 12'h12C;
        for (int m = 0; m < 4; m++) begin
            set_asg({2'(m), 4'h8});
            want[2] <= 1'b0;
            stopd = 1'b1;
            settle();
            want[2] <= 1'b1;
            stopd = 1'b0;
            settle();
        end
        // Servo-on while open latches the stop until off, base block, on
        set_asg(6'h08);
        want[2] <= 1'b0;
        stopd = 1'b1;
        settle();
        pulse(3);
        want[2] <= 1'b1;
        settle();
        rd(ADDR_FLAGS, 33'h042);
        pulse(4);
        want[5] <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        pulse(3);
        stopd = 1'b0;
        settle();
        want[5] <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        stop_test();
    end
endmodule
